// File: verilog/vfd_pipe.sv
/*
 vfd_pipe: fetch, decode and execute phase control of the core pipeline.
 Assumes program memory on the same clock, register file and condition
 logic outside, and a branch unit that reports its redirect in E1.
*/
// Contract
// - fetch eight-word packets moving together
// - address made in generate, sent next phase
// - memory reads in wait; capture in receive
// - exactly four fetch phases per instruction
// - two decode phases: dispatch then decode
// - dispatch splits fetch packet into execute packets
// - execute packet holds one to eight
// - route each instruction to its unit
// - decode holds registers and paths for execution
// - no-ops reach no unit
// - five execute phases, used per type
// - up to eight instructions dispatched per cycle
// - parallel instructions move in lockstep
// - serial instructions keep a fixed offset
// - load and store addresses leave together
// - no interlocks, never stall on registers
// - new execute packet may start each cycle
// - first execute phase: condition, operand read
// - false condition: nothing after first phase
// - single-cycle results written in first phase
// - results usable after last delay slot
`timescale 1ns/1ps
module vfd_pipe #(
   parameter int PC_W = 32
) (
   input  wire logic                                            mclk_i,
   input  wire logic                                            rst_i,
   input  wire logic                                            br_take_i,
   input  wire logic [PC_W-1:0]                                 br_target_i,
   output logic                                                 pm_req_o,
   output logic      [PC_W-1:0]                                 pm_addr_o,
   input  wire logic [vfd_pkg::FP_WORDS*vfd_pkg::WORD_W-1:0]     pm_data_i,
   output logic                                                 fetch_hold_o,
   output logic                                                 ep_issue_o,
   input  wire logic [vfd_pkg::NUM_UNITS-1:0]                    e1_cond_i,
   output logic      [vfd_pkg::NUM_UNITS-1:0]                    e1_valid_o,
   output logic      [vfd_pkg::NUM_UNITS*vfd_pkg::REG_W-1:0]     e1_src1_o,
   output logic      [vfd_pkg::NUM_UNITS*vfd_pkg::REG_W-1:0]     e1_src2_o,
   output logic      [vfd_pkg::NUM_UNITS*vfd_pkg::REG_W-1:0]     e1_dst_o,
   output logic      [vfd_pkg::NUM_UNITS-1:0]                    e1_xpath_o,
   output logic      [vfd_pkg::NUM_UNITS*3-1:0]                  e1_type_o,
   output logic      [vfd_pkg::NUM_UNITS-1:0]                    wb_en_o,
   output logic      [vfd_pkg::NUM_UNITS-1:0]                    mem_addr_en_o,
   output logic      [vfd_pkg::NUM_UNITS-1:0]                    res_avail_o,
   output logic      [vfd_pkg::NUM_UNITS*vfd_pkg::EX_PHASES-1:0] ex_busy_o
);
   localparam int NU      = vfd_pkg::NUM_UNITS;
   localparam int RW      = vfd_pkg::REG_W;
   localparam int EXP     = vfd_pkg::EX_PHASES;
   localparam int FPW     = vfd_pkg::FP_WORDS;
   localparam int WW      = vfd_pkg::WORD_W;
   localparam int FP_BITS = FPW * WW;

   // address must at least step over one packet
   if (PC_W < 6 || PC_W > 32)
   begin : g_pc_check
      $error("vfd_pipe: PC_W must be 6..32");
   end

   ////////////////////////////////////////////////////////////////////////
   // fetch phases
   logic                   stall;        // dispatch still busy
   logic                   pg_v_q;       // generate phase holds an address
   logic [PC_W-1:0]        pg_pc_q;
   logic [PC_W-1:0]        pc_d;
   logic                   brp_q;        // branch seen during a hold
   logic [PC_W-1:0]        brp_pc_q;
   logic                   ps_v_q;       // send phase
   logic [PC_W-1:0]        ps_pc_q;
   logic                   pw_v_q;       // memory wait phase
   logic                   pr_v_q;       // packet at boundary
   logic [FP_BITS-1:0]     pr_data_q;

   // next packet address; a branch overrides the sequential step
   always_comb
   begin
      if (br_take_i)
         pc_d = br_target_i;
      else if (brp_q)
         pc_d = brp_pc_q;
      else
         pc_d = pg_pc_q + PC_W'(vfd_pkg::FP_BYTES);
   end

   // branch arriving in a hold is parked so it is not lost
   always_ff @(posedge mclk_i)
   begin
      if (rst_i || !stall)
         brp_q <= 1'b0;
      else if (br_take_i)
         brp_q <= 1'b1;
      if (br_take_i)
         brp_pc_q <= br_target_i;
   end

   // generate phase: address made inside the core
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         pg_v_q  <= 1'b0;
         pg_pc_q <= PC_W'(vfd_pkg::PC_RESET);
      end
      else if (!stall)
      begin
         pg_v_q  <= 1'b1;
         pg_pc_q <= pg_v_q ? pc_d : pg_pc_q;
      end
   end

   // send, wait and receive phases advance as one
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         ps_v_q <= 1'b0;
         pw_v_q <= 1'b0;
         pr_v_q <= 1'b0;
      end
      else if (!stall)
      begin
         ps_v_q <= pg_v_q;
         pw_v_q <= ps_v_q;
         pr_v_q <= pw_v_q;
      end
   end

   // data paths of the fetch phases
   always_ff @(posedge mclk_i)
   begin
      if (!stall)
      begin
         ps_pc_q   <= pg_pc_q;
         pr_data_q <= pm_data_i;
      end
   end

   assign pm_req_o     = ps_v_q && !stall;
   assign pm_addr_o    = ps_pc_q;
   assign fetch_hold_o = stall;

   ////////////////////////////////////////////////////////////////////////
   // dispatch phase
   vfd_pkg::vfd_dp_state_t dp_state_q;
   logic [FP_BITS-1:0]     dp_words_q;   // held fetch packet
   logic [FPW-1:0]         dp_left_q;    // words not yet dispatched
   logic [FPW-1:0]         pbits;
   logic [FPW-1:0]         ep;           // current execute packet
   logic                   ep_last;
   logic                   dp_busy;

   // gather parallel bits of the held packet
   for (genvar i = 0; i < FPW; i++)
   begin : g_pbit
      assign pbits[i] = dp_words_q[i*WW + vfd_pkg::P_BIT];
   end

   vfd_ep_split u_split (
      .pbits_i (pbits),
      .left_i  (dp_left_q),
      .ep_o    (ep),
      .last_o  (ep_last)
   );

   vfd_slot_if slot_bus ();

   vfd_unit_route u_route (
      .words_i (dp_words_q),
      .ep_i    (ep),
      .slot    (slot_bus.src)
   );

   assign dp_busy    = (dp_state_q == vfd_pkg::DP_HOLD);
   assign stall      = dp_busy && !ep_last;
   assign ep_issue_o = dp_busy;

   // holder: loads from receive, releases one execute packet a cycle
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         dp_state_q <= vfd_pkg::DP_EMPTY;
         dp_left_q  <= '0;
      end
      else
      begin
         case (dp_state_q)
            vfd_pkg::DP_EMPTY:
            begin
               if (pr_v_q)
               begin
                  dp_state_q <= vfd_pkg::DP_HOLD;
                  dp_left_q  <= '1;
               end
            end
            vfd_pkg::DP_HOLD:
            begin
               if (!ep_last)
                  dp_left_q <= dp_left_q & ~ep;
               else if (pr_v_q)
                  dp_left_q <= '1;
               else
               begin
                  dp_state_q <= vfd_pkg::DP_EMPTY;
                  dp_left_q  <= '0;
               end
            end
            default:
            begin
               dp_state_q <= vfd_pkg::DP_EMPTY;
               dp_left_q  <= '0;
            end
         endcase
      end
   end

   // packet words follow the load decision above
   always_ff @(posedge mclk_i)
   begin
      if (pr_v_q && !stall)
         dp_words_q <= pr_data_q;
   end

   ////////////////////////////////////////////////////////////////////////
   // decode phase and first-execute operand fields
   logic [NU-1:0] dc_v_q;                 // unit has a decode slot
   logic [WW-1:0] dc_ins_q [NU];
   logic [NU-1:0] e1_v_q;
   logic [2:0]    e1_ty_q  [NU];
   logic [NU-1:0] live1;                  // in E1 with condition true

   // every unit latches in the same edge, empty slots stay empty
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         dc_v_q <= '0;
      else
         dc_v_q <= dp_busy ? slot_bus.valid : '0;
      if (rst_i)
         e1_v_q <= '0;
      else
         e1_v_q <= dc_v_q;
   end

   // per-unit decode of register selects and path choice
   for (genvar u = 0; u < NU; u++)
   begin : g_dec
      always_ff @(posedge mclk_i)
      begin
         dc_ins_q[u] <= slot_bus.instr[u];
         e1_ty_q[u]  <= dc_ins_q[u][vfd_pkg::TYPE_LSB +: 3];
         e1_src1_o[u*RW +: RW] <= dc_ins_q[u][vfd_pkg::SRC1_LSB +: RW];
         e1_src2_o[u*RW +: RW] <= dc_ins_q[u][vfd_pkg::SRC2_LSB +: RW];
         e1_dst_o[u*RW +: RW]  <= dc_ins_q[u][vfd_pkg::DST_LSB +: RW];
         e1_xpath_o[u]         <= dc_ins_q[u][vfd_pkg::X_BIT];
      end
      assign e1_type_o[u*3 +: 3] = e1_ty_q[u];
   end

   assign e1_valid_o = e1_v_q;
   assign live1      = e1_v_q & e1_cond_i;

   ////////////////////////////////////////////////////////////////////////
   // execute phases two to five
   logic [NU-1:0] xv_q  [2:EXP];          // unit busy in phase k
   logic [2:0]    xty_q [2:EXP][NU];

   // an instruction stays only as long as its type needs
   always_ff @(posedge mclk_i)
   begin
      for (int u = 0; u < NU; u++)
      begin
         xv_q[2][u]  <= !rst_i && live1[u]
                        && (vfd_pkg::ex_len(e1_ty_q[u]) >= 3'h2);
         xty_q[2][u] <= e1_ty_q[u];
         for (int k = 3; k <= EXP; k++)
         begin
            xv_q[k][u]  <= !rst_i && xv_q[k-1][u]
                           && (vfd_pkg::ex_len(xty_q[k-1][u]) >= 3'(k));
            xty_q[k][u] <= xty_q[k-1][u];
         end
      end
   end

   // register writes, memory address strobes and occupancy
   always_comb
   begin
      for (int u = 0; u < NU; u++)
      begin
         wb_en_o[u] = live1[u] && (vfd_pkg::wr_phase(e1_ty_q[u]) == 3'h1);
         ex_busy_o[u*EXP] = e1_v_q[u];
         for (int k = 2; k <= EXP; k++)
         begin
            if (xv_q[k][u] && (vfd_pkg::wr_phase(xty_q[k][u]) == 3'(k)))
               wb_en_o[u] = 1'b1;
            ex_busy_o[u*EXP + k - 1] = xv_q[k][u];
         end
         mem_addr_en_o[u] = xv_q[vfd_pkg::MEM_PHASE][u]
            && ((xty_q[vfd_pkg::MEM_PHASE][u] == vfd_pkg::TY_LOAD)
             || (xty_q[vfd_pkg::MEM_PHASE][u] == vfd_pkg::TY_STORE));
      end
   end

   // result usable the cycle after its write ends the delay slots
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         res_avail_o <= '0;
      else
         res_avail_o <= wb_en_o;
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   sequence s_ld_e1;
      e1_v_q[0] && e1_cond_i[0] && (e1_ty_q[0] == vfd_pkg::TY_LOAD);
   endsequence
   sequence s_st_e1;
      e1_v_q[1] && e1_cond_i[1] && (e1_ty_q[1] == vfd_pkg::TY_STORE);
   endsequence

   a_send_follows: assert property (pm_req_o |=> pw_v_q && !$stable(pw_v_q) || pw_v_q)
      else $error("request did not enter wait phase");
   a_receive_data: assert property (pw_v_q && !stall |=> pr_v_q && pr_data_q == $past(pm_data_i))
      else $error("fetch packet not captured from memory");
   a_dispatch_dc: assert property (dp_busy |=> dc_v_q == $past(slot_bus.valid))
      else $error("dispatched slots missing in decode");
   a_ep_nonempty: assert property (dp_busy |-> ep != '0 && (ep & ~dp_left_q) == '0)
      else $error("empty or stale execute packet");
   a_hold_fetch: assert property (stall |=> $stable(pr_data_q) && $stable(ps_pc_q))
      else $error("fetch moved during dispatch hold");
   a_false_stops: assert property ((e1_v_q[0] && !e1_cond_i[0]) |=> !xv_q[2][0] ##1 !xv_q[3][0])
      else $error("false instruction continued past E1");
   // a load and a store issued together send their addresses in one cycle
   a_ldst_same: assert property ((s_ld_e1 and s_st_e1)
                                 |=> mem_addr_en_o[0] && mem_addr_en_o[1])
      else $error("load/store address phase mismatch");
   a_ld_addr_e2: assert property (s_ld_e1 |=> mem_addr_en_o[0] ##3 wb_en_o[0])
      else $error("load address or write phase wrong");
   // a store sends its address in E2 and frees its unit after E3
   a_st_addr_e2: assert property (s_st_e1 |=> mem_addr_en_o[1] ##2 !ex_busy_o[EXP+3])
      else $error("store address phase wrong");
   a_single_wb: assert property (e1_v_q[2] && e1_cond_i[2] && e1_ty_q[2] == vfd_pkg::TY_SINGLE
                                 |-> wb_en_o[2] ##1 res_avail_o[2])
      else $error("single-cycle result not written in E1");
   a_reset_empty: assert property ($past(rst_i) |-> !pr_v_q && e1_v_q == '0 && dc_v_q == '0)
      else $error("pipeline not empty after reset");
endmodule

// File: verilog/vfd_pkg.sv
/*
 vfd_pkg: constants, field layout and helpers for the fetch/decode/execute
 pipeline control. Assumes eight units, one per slot of a 32-bit packet word.
*/
package vfd_pkg;
   localparam int FP_WORDS  = 8;    // words per fetch packet
   localparam int NUM_UNITS = 8;    // functional units
   localparam int WORD_W    = 32;   // instruction word width
   localparam int EX_PHASES = 5;    // execute phases
   localparam int MEM_PHASE = 2;    // phase where ld/st address leaves
   // instruction word fields
   localparam int P_BIT     = 0;    // parallel-with-next bit
   localparam int UNIT_LSB  = 1;    // unit select
   localparam int UNIT_W    = 3;
   localparam int TYPE_LSB  = 4;    // instruction type
   localparam int TYPE_W    = 3;
   localparam int X_BIT     = 12;   // cross path select
   localparam int SRC1_LSB  = 13;
   localparam int SRC2_LSB  = 18;
   localparam int DST_LSB   = 23;
   localparam int REG_W     = 5;
   localparam logic [31:0] NOP_WORD  = 32'h0000_0000;
   localparam logic [31:0] PC_RESET  = 32'h0000_0000;
   localparam logic [31:0] FP_BYTES  = 32'h0000_0020;
   // instruction type codes
   localparam logic [2:0] TY_SINGLE = 3'h0;
   localparam logic [2:0] TY_TWO    = 3'h1;
   localparam logic [2:0] TY_STORE  = 3'h2;
   localparam logic [2:0] TY_FOUR   = 3'h3;
   localparam logic [2:0] TY_LOAD   = 3'h4;
   localparam logic [2:0] TY_BRANCH = 3'h5;

   // dispatch holder state
   typedef enum logic [1:0] {DP_EMPTY = 2'b01, DP_HOLD = 2'b10} vfd_dp_state_t;

   // execute phases that a type occupies
   function automatic logic [2:0] ex_len(input logic [2:0] ty);
      case (ty)
         TY_TWO:   ex_len = 3'h2;
         TY_STORE: ex_len = 3'h3;
         TY_FOUR:  ex_len = 3'h4;
         TY_LOAD:  ex_len = 3'h5;
         default:  ex_len = 3'h1;
      endcase
   endfunction

   // phase of register write, zero when none
   function automatic logic [2:0] wr_phase(input logic [2:0] ty);
      case (ty)
         TY_SINGLE: wr_phase = 3'h1;
         TY_TWO:    wr_phase = 3'h2;
         TY_FOUR:   wr_phase = 3'h4;
         TY_LOAD:   wr_phase = 3'h5;
         default:   wr_phase = 3'h0;
      endcase
   endfunction

   function automatic logic [2:0] unit_of(input logic [31:0] w);
      unit_of = w[UNIT_LSB +: UNIT_W];
   endfunction
endpackage

// File: verilog/vfd_slot_if.sv
/*
 vfd_slot_if: per-unit dispatch slots, router to pipeline top.
 Assumes one slot per functional unit.
*/
`timescale 1ns/1ps
interface vfd_slot_if;
   logic [vfd_pkg::NUM_UNITS-1:0] valid;                     // slot holds an instruction
   logic [vfd_pkg::WORD_W-1:0]    instr [vfd_pkg::NUM_UNITS]; // routed word
   modport src (output valid, output instr);
   modport dst (input valid, input instr);
endinterface

// File: verilog/vfd_ep_split.sv
/*
 vfd_ep_split: finds the next execute packet among the words still left
 in the held fetch packet. Assumes left_i is contiguous up to the top word.
*/
`timescale 1ns/1ps
module vfd_ep_split (
   input  wire logic [vfd_pkg::FP_WORDS-1:0] pbits_i,
   input  wire logic [vfd_pkg::FP_WORDS-1:0] left_i,
   output logic      [vfd_pkg::FP_WORDS-1:0] ep_o,
   output logic                              last_o
);
   logic done;   // packet end already seen

   // collect words until one without the parallel bit
   always_comb
   begin
      ep_o = '0;
      done = 1'b0;
      for (int i = 0; i < vfd_pkg::FP_WORDS; i++)
      begin
         if (left_i[i] && !done)
         begin
            ep_o[i] = 1'b1;
            done    = !pbits_i[i];
         end
      end
      // top word closes a packet even with its bit set
      last_o = ((left_i & ~ep_o) == '0);
   end
endmodule

// File: verilog/vfd_unit_route.sv
/*
 vfd_unit_route: steers each word of the current execute packet to the
 unit it selects; no-ops go nowhere. Assumes one word per unit per packet.
*/
`timescale 1ns/1ps
module vfd_unit_route (
   input  wire logic [vfd_pkg::FP_WORDS*vfd_pkg::WORD_W-1:0] words_i,
   input  wire logic [vfd_pkg::FP_WORDS-1:0]                 ep_i,
   vfd_slot_if.src                                           slot
);
   logic [vfd_pkg::WORD_W-1:0] w;   // word under test

   // last matching word wins; software never doubles a unit
   always_comb
   begin
      w = '0;
      slot.valid = '0;
      for (int u = 0; u < vfd_pkg::NUM_UNITS; u++)
      begin
         slot.instr[u] = vfd_pkg::NOP_WORD;
      end
      for (int i = 0; i < vfd_pkg::FP_WORDS; i++)
      begin
         w = words_i[i*vfd_pkg::WORD_W +: vfd_pkg::WORD_W];
         if (ep_i[i] && (w != vfd_pkg::NOP_WORD))
         begin
            slot.valid[vfd_pkg::unit_of(w)] = 1'b1;
            slot.instr[vfd_pkg::unit_of(w)] = w;
         end
      end
   end
endmodule

// File: tb/vfd_pmem_model.sv
/*
 vfd_pmem_model: program memory beside the pipe, one eight-word packet per
 request. Assumes the pipe's clock, and no request while fetch is frozen.
*/
`timescale 1ns/1ps
module vfd_pmem_model (
   input  wire logic         mclk_i,
   input  wire logic         rst_i,
   input  wire logic         req_i,
   input  wire logic [31:0]  addr_i,
   input  wire logic         hold_i,
   output logic      [255:0] data_o
);
   logic [31:0] mem [64]; // program image, filled by the bench
   logic        busy_q;   // a packet stands on the data lines

   initial data_o = '0;
   initial busy_q = 1'b0;

   ////////////////////////////////////////////////////////////////////////
   // read in the wait cycle; a frozen fetch keeps the packet standing
   always @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         busy_q <= 1'b0;
         data_o <= ~data_o;
      end
      else if (busy_q && hold_i)
      begin
         data_o <= data_o;
      end
      else if (req_i)
      begin
         busy_q <= 1'b1;
         // word 0 at the lowest address, image wraps every 256 bytes
         for (int i = 0; i < 8; i++)
            data_o[32*i +: 32] <= mem[{addr_i[7:5], 3'(i)}];
      end
      else
      begin
         // released lines toggle so a stale packet can never pass
         busy_q <= 1'b0;
         data_o <= ~data_o;
      end
   end
endmodule

// File: tb/vfd_pipe_test.sv
/*
 vfd_pipe_test: random program through the pipe with corner packets,
 branches, random conditions and a reset in mid-run. Assumes vfd_pipe
 with default width and the memory model on the fetch side.
*/
`timescale 1ns/1ps
module vfd_pipe_test;
   logic         mclk_i, rst_i, br_take_i, pm_req_o, fetch_hold_o, ep_issue_o;
   logic [31:0]  br_target_i, pm_addr_o, exp_pc, tgt, w;
   logic [255:0] pm_data_i, r;
   logic [7:0]   e1_cond_i, e1_valid_o, e1_xpath_o, wb_en_o, mem_addr_en_o, res_avail_o;
   logic [7:0]   m, ewb, emem, last_wb;
   logic [39:0]  e1_src1_o, e1_src2_o, e1_dst_o, ex_busy_o;
   logic [23:0]  e1_type_o;
   logic [5:0]   pwb [8];   // pending writes per unit, bit k = k cycles ahead
   logic [1:0]   pmem [8];  // pending memory address per unit
   logic [1:0]   iss;       // dispatch history, two cycles deep
   logic         br_pend, rst_q, br_held;
   logic [24:0]  fb [8];    // expected occupancy per unit, five bits per cycle ahead
   logic [7:0]   qm [$];    // expected E1 masks in order
   logic [255:0] qw [$];    // expected routed words in order
   int           errors, compares, seq_n, hcnt, l;

   vfd_pipe i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .br_take_i(br_take_i),
      .br_target_i(br_target_i), .pm_req_o(pm_req_o), .pm_addr_o(pm_addr_o),
      .pm_data_i(pm_data_i), .fetch_hold_o(fetch_hold_o), .ep_issue_o(ep_issue_o),
      .e1_cond_i(e1_cond_i), .e1_valid_o(e1_valid_o), .e1_src1_o(e1_src1_o),
      .e1_src2_o(e1_src2_o), .e1_dst_o(e1_dst_o), .e1_xpath_o(e1_xpath_o),
      .e1_type_o(e1_type_o), .wb_en_o(wb_en_o), .mem_addr_en_o(mem_addr_en_o),
      .res_avail_o(res_avail_o), .ex_busy_o(ex_busy_o));

   vfd_pmem_model i_mem (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(pm_req_o),
      .addr_i(pm_addr_o), .hold_i(fetch_hold_o), .data_o(pm_data_i));

   ////////////////////////////////////////////////////////////////////////
   // compare, count, report
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic end_sim();
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // execute phase of the register write per type, zero for none
   function automatic int wlat(input logic [2:0] ty);
      case (ty)
         3'h0:    return 1;
         3'h1:    return 2;
         3'h3:    return 4;
         3'h4:    return 5;
         default: return 0;
      endcase
   endfunction

   // execute phases a type occupies
   function automatic int elen(input logic [2:0] ty);
      case (ty)
         3'h1:    return 2;
         3'h2:    return 3;
         3'h3:    return 4;
         3'h4:    return 5;
         default: return 1;
      endcase
   endfunction

   // split one packet into expected execute packets; no-ops route nowhere
   task automatic split(input logic [31:0] a);
      logic [7:0]   sm;
      logic [255:0] sr;
      logic [31:0]  sw;
      sm = '0;
      sr = '0;
      for (int i = 0; i < 8; i++)
      begin
         sw = i_mem.mem[{a[7:5], 3'(i)}];
         if (sw !== vfd_pkg::NOP_WORD)
         begin
            sm[sw[3:1]] = 1'b1;
            sr[32*sw[3:1] +: 32] = sw; // higher word wins
         end
         if (!sw[0] || i == 7)
         begin
            qm.push_back(sm);
            qw.push_back(sr);
            sm = '0;
            sr = '0;
         end
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      mclk_i = 1'b0;
      forever #20 mclk_i = ~mclk_i;
   end

   // random conditions every cycle, an occasional branch
   always @(posedge mclk_i)
   begin
      e1_cond_i <= 8'($urandom);
      br_take_i <= 1'b0;
      if (!rst_i && !br_pend && !br_take_i && $urandom_range(0, 40) == 0)
      begin
         br_take_i   <= 1'b1;
         br_target_i <= {24'h00_0000, 3'($urandom), 5'h00};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // monitor on the falling edge, where all outputs have settled
   always @(negedge mclk_i)
   begin
      // the pipe only resets at the edge after rst_i is seen
      if (rst_q)
         chk(64'({pm_req_o, fetch_hold_o, ep_issue_o, e1_valid_o, wb_en_o,
                  mem_addr_en_o, res_avail_o}), 64'h0);
      rst_q = rst_i;
      if (rst_i)
      begin
         qm.delete();
         qw.delete();
         exp_pc = 32'h0000_0000;
         br_pend = 1'b0;
         iss = 2'b00;
         last_wb = '0;
         hcnt = 0;
         for (int u = 0; u < 8; u++)
         begin
            pwb[u] = '0;
            pmem[u] = '0;
            fb[u] = '0;
         end
      end
      else
      begin
         // fetch addresses: sequential, or the branch target
         // one sequential packet precedes the target, two if it met a hold
         if (pm_req_o)
         begin
            if (br_pend && seq_n == (br_held ? 2 : 1))
            begin
               chk(64'(pm_addr_o), 64'(tgt));
               br_pend = 1'b0;
            end
            else
            begin
               chk(64'(pm_addr_o), 64'(exp_pc));
               if (br_pend)
                  seq_n++;
            end
            exp_pc = pm_addr_o + vfd_pkg::FP_BYTES;
            split(pm_addr_o);
         end
         if (br_take_i)
         begin
            br_pend = 1'b1;
            br_held = fetch_hold_o;
            tgt = br_target_i;
            seq_n = 0;
         end
         // a frozen fetch must end; a hang ends the run
         hcnt = fetch_hold_o ? hcnt + 1 : 0;
         if (hcnt > 16)
         begin
            chk(64'(hcnt), 64'h0);
            end_sim();
         end
         // E1 exactly two cycles after dispatch
         m = '0;
         r = '0;
         if (iss[1])
         begin
            if (qm.size() == 0)
               chk(64'h1, 64'h0);
            else
            begin
               m = qm.pop_front();
               r = qw.pop_front();
            end
         end
         chk(64'(e1_valid_o), 64'(m));
         for (int u = 0; u < 8; u++)
            if (m[u])
            begin
               w = r[32*u +: 32];
               chk(64'({e1_dst_o[5*u +: 5], e1_src2_o[5*u +: 5], e1_src1_o[5*u +: 5],
                        e1_xpath_o[u], e1_type_o[3*u +: 3]}),
                   64'({w[27:23], w[22:18], w[17:13], w[12], w[6:4]}));
               l = wlat(w[6:4]);
               if (e1_cond_i[u] && l > 0)
                  pwb[u][l-1] = 1'b1;
               if (e1_cond_i[u] && (w[6:4] == 3'h2 || w[6:4] == 3'h4))
                  pmem[u][1] = 1'b1;
               // phase d+1 busy d cycles ahead while the type needs it
               if (e1_cond_i[u])
                  for (int d = 1; d < elen(w[6:4]); d++)
                     fb[u][6*d] = 1'b1;
            end
         // write-back, memory address and result timing per unit
         for (int u = 0; u < 8; u++)
         begin
            ewb[u] = pwb[u][0];
            emem[u] = pmem[u][0];
            pwb[u] = pwb[u] >> 1;
            pmem[u] = pmem[u] >> 1;
            fb[u][0] = m[u];
            chk(64'(ex_busy_o[5*u +: 5]), 64'(fb[u][4:0]));
            fb[u] = fb[u] >> 5;
         end
         chk(64'(wb_en_o), 64'(ewb));
         chk(64'(mem_addr_en_o), 64'(emem));
         chk(64'(res_avail_o), 64'(last_wb));
         last_wb = ewb;
         iss = {iss[0], ep_issue_o};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // corner packets first: eight parallel, all no-ops, eight serial,
   // parallel bit set on the top word; random packets after
   initial
   begin
      errors = 0;
      compares = 0;
      rst_q = 1'b1;
      rst_i = 1'b1;
      br_take_i = 1'b0;
      br_target_i = 32'h0000_0000;
      e1_cond_i = 8'h00;
      void'($urandom(5445));
      for (int k = 0; k < 64; k++)
      begin
         w = $urandom;
         w[6:4] = 3'($urandom_range(0, 5));
         if (k < 32)
            w[3:1] = 3'(k);
         case (k / 8)
            0:       w[0] = (k != 7);
            1:       w = vfd_pkg::NOP_WORD;
            2:       w[0] = 1'b0;
            3:       w[0] = 1'b1;
            default: if ($urandom_range(0, 5) == 0) w = vfd_pkg::NOP_WORD;
         endcase
         i_mem.mem[k] = w;
      end
      repeat (4) @(posedge mclk_i);
      rst_i <= 1'b0;
      repeat (3000) @(posedge mclk_i);
      rst_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      rst_i <= 1'b0;
      repeat (2000) @(posedge mclk_i);
      end_sim();
   end
endmodule
